// *** xrp_pkg.sv ***
// shared constants for the receive parallel output block
package xrp_pkg;
  // ----------------------------------------------------------------
  // lane structure
  // ----------------------------------------------------------------
  localparam int LANES = 4;
  localparam int DATA_W = 8;
  localparam int BUS_W = 10;
  localparam int FLAG_K_BIT = 8;
  localparam int FLAG_ERR_BIT = 9;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int MCLK_PERIOD_NS = 40;
  localparam int RX_HALF_NS = 160;
  localparam int RX_HALF_CYC = (RX_HALF_NS / MCLK_PERIOD_NS) < 2 ? 2 :
                               (RX_HALF_NS / MCLK_PERIOD_NS);
  localparam int RX_MID_CYC = RX_HALF_CYC / 2;
  localparam int CNT_W = 8;
  // reset phase of each lane's own recovered clock divider
  localparam logic [CNT_W-1:0] LANE_PHASE [LANES] = '{8'h00, 8'h01, 8'h02, 8'h03};
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [BUS_W-1:0] BUS_RST = 10'h000;
  localparam logic RX_CLK_RST = 1'b0;
endpackage

// *** xrp_lane.sv ***
// one lane's ten-bit receive output word
`timescale 1ns/100ps
module xrp_lane
  import xrp_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // control
  input wire logic upd_i,
  input wire logic code_en_i,
  // word from decoder
  input wire logic [xrp_pkg::BUS_W-1:0] code_grp_i,
  input wire logic [xrp_pkg::DATA_W-1:0] dec_data_i,
  input wire logic k_i,
  input wire logic err_i,
  // output
  output logic [xrp_pkg::BUS_W-1:0] bus_o
);
  import xrp_pkg::*;

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      bus_o <= BUS_RST;
    end else if (upd_i) begin
      if (code_en_i) begin
        // decoded word carries its own flags
        bus_o <= {err_i, k_i, dec_data_i};
      end else begin
        bus_o <= code_grp_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_RAW_PASS: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    upd_i && !code_en_i |=> bus_o == $past(code_grp_i))
    else $error("raw word not passed through");
  AST_KFLAG: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    upd_i && code_en_i |=> bus_o[FLAG_K_BIT] == $past(k_i)
      && bus_o[DATA_W-1:0] == $past(dec_data_i))
    else $error("k flag or data wrong in coded mode");
  AST_ERRFLAG: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    upd_i && code_en_i && err_i |=> bus_o[FLAG_ERR_BIT])
    else $error("error flag not raised");
  AST_PLAIN_DATA: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    upd_i && code_en_i && !k_i && !err_i |=> bus_o[FLAG_ERR_BIT:FLAG_K_BIT] == 2'b00)
    else $error("flags high on plain data word");
endmodule

// *** xrp_rx_out.sv ***
// receive parallel output: four DDR lanes with source clocks
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/100ps
module xrp_rx_out
  import xrp_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // mode pins, asynchronous
  input wire logic shared_clock_select_i,
  input wire logic code_enable_i,
  // decoded words per lane, same clock
  input wire logic [xrp_pkg::LANES-1:0][xrp_pkg::BUS_W-1:0] code_grp_i,
  input wire logic [xrp_pkg::LANES-1:0][xrp_pkg::DATA_W-1:0] dec_data_i,
  input wire logic [xrp_pkg::LANES-1:0] k_char_i,
  input wire logic [xrp_pkg::LANES-1:0] dec_err_i,
  output logic [xrp_pkg::LANES-1:0] word_taken_o,
  // receive buses
  output logic [xrp_pkg::BUS_W-1:0] rx_lane_a_bus_o,
  output logic [xrp_pkg::BUS_W-1:0] rx_lane_b_bus_o,
  output logic [xrp_pkg::BUS_W-1:0] rx_lane_c_bus_o,
  output logic [xrp_pkg::BUS_W-1:0] rx_lane_d_bus_o,
  // receive clocks
  output logic rx_clock_lane_a_o,
  output logic rx_clock_lane_b_o,
  output logic rx_clock_lane_c_o,
  output logic rx_clock_lane_d_o
);
  import xrp_pkg::*;

  localparam int HALF = RX_HALF_CYC;
  localparam int MID = RX_MID_CYC;
  // outputs show a clock edge two cycles after cnt 0; the bus moves MID cycles, a quarter period, after that
  localparam int UPD_AT = (MID + 1) % HALF;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic share_meta;
  logic share_q;
  logic code_meta;
  logic code_q;

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      share_meta <= 1'b0;
      share_q <= 1'b0;
    end else begin
      share_meta <= shared_clock_select_i;
      share_q <= share_meta;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      code_meta <= 1'b0;
      code_q <= 1'b0;
    end else begin
      code_meta <= code_enable_i;
      code_q <= code_meta;
    end
  end

  // strobes stay quiet through reset, so no word is taken from reset-time inputs
  logic live;

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      live <= 1'b0;
    end else begin
      live <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // sharing settle tracker, read by the checks only
  // ----------------------------------------------------------------
  // a lane that swaps clocks sees one or two short or long half periods
  logic share_d;
  logic [CNT_W-1:0] share_age;
  logic share_steady;

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      share_d <= 1'b0;
      share_age <= '0;
    end else begin
      share_d <= share_q;
      if (share_q != share_d) begin
        share_age <= '0;
      end else if (share_age != CNT_W'(2 * HALF)) begin
        share_age <= share_age + CNT_W'(1);
      end
    end
  end

  assign share_steady = (share_q == share_d) && (share_age == CNT_W'(2 * HALF));

  // ----------------------------------------------------------------
  // per-lane clock dividers and output stage
  // ----------------------------------------------------------------
  logic [LANES-1:0] own_clk;
  logic [LANES-1:0] own_tgl;
  logic [LANES-1:0] own_upd;
  logic [LANES-1:0] sel_upd;
  logic [LANES-1:0] next_rx_clk;
  logic [LANES-1:0] rx_clk;
  logic [LANES-1:0][BUS_W-1:0] lane_bus;
  logic [LANES-1:0][CNT_W-1:0] cnt;

  genvar l;
  generate
    for (l = 0; l < LANES; l++) begin : g_lane
      assign own_tgl[l] = (cnt[l] == CNT_W'(0));
      // data moves mid-way between clock edges, so both edges see it settled
      assign own_upd[l] = live && (cnt[l] == CNT_W'(UPD_AT));

      always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
          cnt[l] <= LANE_PHASE[l];
        end else if (cnt[l] == CNT_W'(HALF - 1)) begin
          cnt[l] <= CNT_W'(0);
        end else begin
          cnt[l] <= cnt[l] + CNT_W'(1);
        end
      end

      always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
          own_clk[l] <= RX_CLK_RST;
        end else if (own_tgl[l]) begin
          own_clk[l] <= ~own_clk[l];
        end
      end

      if (l == 0) begin : g_a
        assign sel_upd[l] = own_upd[0];
        assign next_rx_clk[l] = own_clk[0];
      end else begin : g_bcd
        // data, flag and error bits all ride on the same strobe
        assign sel_upd[l] = share_q ? own_upd[0] : own_upd[l];
        assign next_rx_clk[l] = share_q ? own_clk[0] : own_clk[l];
      end

      always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
          rx_clk[l] <= RX_CLK_RST;
        end else begin
          rx_clk[l] <= next_rx_clk[l];
        end
      end

      always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
          word_taken_o[l] <= 1'b0;
        end else begin
          word_taken_o[l] <= sel_upd[l];
        end
      end

      xrp_lane u_lane (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .upd_i(sel_upd[l]),
        .code_en_i(code_q),
        .code_grp_i(code_grp_i[l]),
        .dec_data_i(dec_data_i[l]),
        .k_i(k_char_i[l]),
        .err_i(dec_err_i[l]),
        .bus_o(lane_bus[l])
      );

      // ------------------------------------------------------------
      // checks
      // ------------------------------------------------------------
      sequence s_edge;
        $changed(rx_clk[l]);
      endsequence
      sequence s_hold;
        $stable(lane_bus[l]) ##1 $stable(lane_bus[l]);
      endsequence

      AST_STABLE_AT_EDGE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        share_steady ##0 s_edge |-> s_hold)
        else $error("lane bus moved at its receive clock edge");
      AST_BUS_ON_STROBE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        $changed(lane_bus[l]) |-> $past(sel_upd[l]))
        else $error("lane bus changed without its strobe");
      AST_EDGE_SPACING: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        share_q [*3] ##0 s_edge |=> !$changed(rx_clk[l]) [*1])
        else $error("receive clock edges too close");
      AST_UPD_AFTER_EDGE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        live && own_tgl[l] |-> ##UPD_AT own_upd[l])
        else $error("update not mid-way after clock toggle");
      AST_TAKEN_MARK: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        word_taken_o[l] == $past(sel_upd[l]))
        else $error("word taken flag does not follow the lane strobe");
    end
  endgenerate

  // ----------------------------------------------------------------
  // output mapping
  // ----------------------------------------------------------------
  assign rx_lane_a_bus_o = lane_bus[0];
  assign rx_lane_b_bus_o = lane_bus[1];
  assign rx_lane_c_bus_o = lane_bus[2];
  assign rx_lane_d_bus_o = lane_bus[3];
  assign rx_clock_lane_a_o = rx_clk[0];
  assign rx_clock_lane_b_o = rx_clk[1];
  assign rx_clock_lane_c_o = rx_clk[2];
  assign rx_clock_lane_d_o = rx_clk[3];

  // ----------------------------------------------------------------
  // sharing checks
  // ----------------------------------------------------------------
  AST_CLK_COPY: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    share_q && $past(share_q) |-> rx_clk[1] == rx_clk[0] && rx_clk[2] == rx_clk[0]
      && rx_clk[3] == rx_clk[0])
    else $error("lane B-D clocks do not copy lane A while shared");
  AST_SHARED_STROBE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    share_q && sel_upd[0] |-> sel_upd[3] && sel_upd[2] && sel_upd[1])
    else $error("shared lanes not updated with lane A");
  AST_OWN_STROBE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    !share_q |-> sel_upd == own_upd)
    else $error("unshared lane not on its own strobe");
endmodule

// *** xrp_mac_model.sv ***
// far-side receive model: takes each lane's word on both edges of its clock
`timescale 1ns/100ps
module xrp_mac_model
  import xrp_pkg::*;
(
  // clock
  input wire logic mclk_i,
  // receive buses and clocks
  input wire logic [xrp_pkg::LANES-1:0][xrp_pkg::BUS_W-1:0] bus_i,
  input wire logic [xrp_pkg::LANES-1:0] rx_clk_i,
  // captured words
  output logic [xrp_pkg::LANES-1:0][xrp_pkg::BUS_W-1:0] cap_o,
  output logic [xrp_pkg::LANES-1:0] cap_v_o
);
  import xrp_pkg::*;
  logic [LANES-1:0] clk_q = '0;
  // an edge is seen one cycle late, while the word is still steady
  always_ff @(posedge mclk_i) begin
    clk_q <= rx_clk_i;
    for (int l = 0; l < LANES; l++) begin
      cap_v_o[l] <= rx_clk_i[l] != clk_q[l];
      if (rx_clk_i[l] != clk_q[l]) begin
        cap_o[l] <= bus_i[l];
      end
    end
  end
endmodule

// *** xrp_rx_out_test.sv ***
// self-checking bench for the receive parallel output block
`timescale 1ns/100ps
module xrp_rx_out_test;
  import xrp_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic shared_clock_select_i = 1'b0;
  logic code_enable_i = 1'b0;
  logic [LANES-1:0][BUS_W-1:0] code_grp_i = '0;
  logic [LANES-1:0][DATA_W-1:0] dec_data_i = '0;
  logic [LANES-1:0] k_char_i = '0;
  logic [LANES-1:0] dec_err_i = '0;
  logic [LANES-1:0] word_taken_o;
  wire [LANES-1:0][BUS_W-1:0] bus;
  wire [LANES-1:0] rclk;
  logic [LANES-1:0][BUS_W-1:0] cap;
  logic [LANES-1:0] cap_v;
  logic [LANES-1:0][BUS_W-1:0] e1 = '0;
  logic [LANES-1:0][BUS_W-1:0] last = '0;
  int gap [LANES] = '{default: 0};
  int err_total = 0;
  int total_checks = 0;
  int settle = 20;
  bit quiet = 1'b0;
  logic [31:0] seed = 32'h3C3B;

  xrp_rx_out dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .shared_clock_select_i(shared_clock_select_i), .code_enable_i(code_enable_i),
    .code_grp_i(code_grp_i), .dec_data_i(dec_data_i), .k_char_i(k_char_i),
    .dec_err_i(dec_err_i), .word_taken_o(word_taken_o),
    .rx_lane_a_bus_o(bus[0]), .rx_lane_b_bus_o(bus[1]),
    .rx_lane_c_bus_o(bus[2]), .rx_lane_d_bus_o(bus[3]),
    .rx_clock_lane_a_o(rclk[0]), .rx_clock_lane_b_o(rclk[1]),
    .rx_clock_lane_c_o(rclk[2]), .rx_clock_lane_d_o(rclk[3]));
  xrp_mac_model far_end (.mclk_i(mclk_i), .bus_i(bus), .rx_clk_i(rclk),
    .cap_o(cap), .cap_v_o(cap_v));

  initial begin
    forever #20 mclk_i = ~mclk_i;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  function automatic logic [BUS_W-1:0] exp_word(input logic cd, input logic [BUS_W-1:0] g,
      input logic [DATA_W-1:0] d, input logic k, input logic e);
    return cd ? {e, k, d} : g;
  endfunction

  task automatic check(input logic [BUS_W-1:0] seen, input logic [BUS_W-1:0] want);
    total_checks++;
    if (seen !== want) begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  // random words every cycle; quiet keeps both flags clear
  always @(posedge mclk_i) begin
    for (int l = 0; l < LANES; l++) begin
      seed = xs(seed);
      code_grp_i[l] <= seed[9:0];
      dec_data_i[l] <= seed[17:10];
      k_char_i[l] <= seed[18] & ~quiet;
      dec_err_i[l] <= seed[19] & ~quiet;
    end
  end

  // a word shown with word_taken was driven one cycle before, so e1 still holds it
  always @(negedge mclk_i) begin
    if (rst_b_i !== 1'b1) begin
      settle = 20;
    end else if (settle > 0) begin
      settle--;
    end
    for (int l = 0; l < LANES; l++) begin
      e1[l] <= exp_word(code_enable_i, code_grp_i[l], dec_data_i[l], k_char_i[l], dec_err_i[l]);
      if (word_taken_o[l] === 1'b1 || settle > 0) begin
        gap[l] = 0;
      end else begin
        gap[l]++;
      end
      if (word_taken_o[l] === 1'b1) begin
        last[l] <= e1[l];
        if (settle == 0) check(bus[l], e1[l]);
      end
      if (cap_v[l] === 1'b1 && settle == 0) check(cap[l], last[l]);
      if (gap[l] >= RX_HALF_CYC) begin
        check(BUS_W'(gap[l]), BUS_W'(RX_HALF_CYC - 1));
        gap[l] = 0;
      end
    end
    if (settle == 0 && shared_clock_select_i) check(BUS_W'(rclk), BUS_W'({4{rclk[0]}}));
  end

  task automatic do_reset();
    @(posedge mclk_i);
    rst_b_i <= 1'b0;
    repeat (10) @(posedge mclk_i);
    @(negedge mclk_i);
    for (int l = 0; l < LANES; l++) check(bus[l], BUS_RST);
    check(BUS_W'({rclk, word_taken_o}), BUS_W'({{LANES{RX_CLK_RST}}, 4'h0}));
    @(posedge mclk_i);
    rst_b_i <= 1'b1;
  endtask

  // mode pins change mid-stream; checks pause while they settle
  task automatic run(input logic sh, input logic cd, input bit q, input int n);
    @(posedge mclk_i);
    shared_clock_select_i <= sh;
    code_enable_i <= cd;
    quiet <= q;
    settle = 20;
    repeat (n) @(posedge mclk_i);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    err_total++;
    close_out();
  end

  initial begin
    do_reset();
    run(1'b0, 1'b0, 1'b0, 200);
    run(1'b0, 1'b1, 1'b0, 200);
    run(1'b0, 1'b1, 1'b1, 100);
    run(1'b1, 1'b1, 1'b0, 200);
    run(1'b1, 1'b0, 1'b0, 200);
    do_reset();
    run(1'b0, 1'b1, 1'b0, 100);
    close_out();
  end
endmodule
